// *** arcl_params.svh ***
// Constants for the analog remote control logic
`ifndef ARCL_PARAMS_SVH
`define ARCL_PARAMS_SVH
`define ARCL_SP_W 12
`define ARCL_OUT_W 16
`define ARCL_FULL_5V 12'h800
`define ARCL_FULL_10V 12'hFFF
`define ARCL_OUT_FS 16'hFFFF
`define ARCL_ZERO_OUT 16'h0000
`endif

// *** arcl_pkg.sv ***
// Types for the analog remote control logic
package arcl_pkg;
  typedef enum logic [1:0] {
    ARCL_MODE_CV,
    ARCL_MODE_CC,
    ARCL_MODE_CP
  } arcl_reg_mode_t;
  typedef enum logic {
    ARCL_POL_HIGH,
    ARCL_POL_LOW
  } arcl_pol_t;
endpackage : arcl_pkg

// *** arcl_scaler.sv ***
// Setpoint scaler: sample over range maximum to output full scale
`timescale 1ns/1ns
`include "arcl_params.svh"
module arcl_scaler (
  input wire logic [`ARCL_SP_W-1:0] sample_i,
  input wire logic range_10v_i,
  output logic [`ARCL_OUT_W-1:0] scaled_o
);
  logic [`ARCL_SP_W-1:0] full;
  logic [`ARCL_SP_W+`ARCL_OUT_W-1:0] prod;
  always_comb begin
    full = range_10v_i ? `ARCL_FULL_10V : `ARCL_FULL_5V;
    prod = {{`ARCL_OUT_W{1'b0}}, sample_i} * {{`ARCL_SP_W{1'b0}}, `ARCL_OUT_FS};
    // Above the range maximum the result pins to full scale
    if (sample_i >= full) begin
      scaled_o = `ARCL_OUT_FS;
    end else begin
      scaled_o = `ARCL_OUT_W'(prod / {{`ARCL_OUT_W{1'b0}}, full});
    end
  end
endmodule : arcl_scaler

// *** arcl_top.sv ***
// Analog remote control and status logic
`timescale 1ns/1ns
`include "arcl_params.svh"
module arcl_top
  import arcl_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic alarm_clear_in_i,
  input wire logic alarm_shutdown_i,
  input wire logic output_switch_in_i,
  input wire logic external_control_enable_i,
  input wire logic polarity_low_i,
  input wire logic protection_trip_i,
  input wire logic range_10v_i,
  input wire logic volt_ctrl_sel_i,
  input wire logic curr_ctrl_sel_i,
  input wire logic [1:0] reg_mode_i,
  input wire logic [`ARCL_SP_W-1:0] external_setpoint_voltage_i,
  input wire logic [`ARCL_SP_W-1:0] external_setpoint_current_i,
  input wire logic [`ARCL_OUT_W-1:0] panel_volt_set_i,
  input wire logic [`ARCL_OUT_W-1:0] panel_curr_set_i,
  output logic output_on_o,
  output logic output_active_flag_o,
  output logic power_up_flag_n_o,
  output logic fault_flag_o,
  output logic const_volt_flag_o,
  output logic const_curr_flag_o,
  output logic const_pow_flag_o,
  output logic [`ARCL_OUT_W-1:0] volt_set_o,
  output logic [`ARCL_OUT_W-1:0] curr_set_o
);
  // ----------------------------------------
  // Input qualification
  // ----------------------------------------
  logic ext_en;
  logic clr;
  logic shut;
  logic sw_on;
  logic alarm_ff;
  logic nxt_alarm;
  logic nxt_on;
  logic [`ARCL_OUT_W-1:0] v_scaled;
  logic [`ARCL_OUT_W-1:0] i_scaled;
  arcl_pol_t pol;
  arcl_reg_mode_t mode;

  assign pol = polarity_low_i ? ARCL_POL_LOW : ARCL_POL_HIGH;
  assign mode = arcl_reg_mode_t'(reg_mode_i);
  assign ext_en = external_control_enable_i;
  // Pins are dead while enable is low, so a floating cable cannot act
  assign clr = ext_en & alarm_clear_in_i;
  assign shut = ext_en & alarm_shutdown_i;
  assign sw_on = (pol == ARCL_POL_HIGH) ? output_switch_in_i
                                        : ~output_switch_in_i;

  // ----------------------------------------
  // Alarm latch
  // ----------------------------------------
  // A live cause beats a clear, so a standing fault cannot be cleared away
  assign nxt_alarm = shut | protection_trip_i | (alarm_ff & ~clr);

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      alarm_ff <= 1'b0;
    end else begin
      alarm_ff <= nxt_alarm;
    end
  end

  // ----------------------------------------
  // Output switch
  // ----------------------------------------
  // Switch applies only under external control; otherwise output stays off
  assign nxt_on = ext_en & sw_on & ~nxt_alarm;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      output_on_o <= 1'b0;
      output_active_flag_o <= 1'b0;
      fault_flag_o <= 1'b0;
      power_up_flag_n_o <= 1'b1;
    end else begin
      output_on_o <= nxt_on;
      output_active_flag_o <= nxt_on;
      fault_flag_o <= nxt_alarm;
      power_up_flag_n_o <= 1'b0;
    end
  end

  // ----------------------------------------
  // Regulation mode flags
  // ----------------------------------------
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      const_volt_flag_o <= 1'b0;
      const_curr_flag_o <= 1'b0;
      const_pow_flag_o <= 1'b0;
    end else begin
      const_volt_flag_o <= 1'b0;
      const_curr_flag_o <= 1'b0;
      const_pow_flag_o <= 1'b0;
      unique case (mode)
        ARCL_MODE_CV: const_volt_flag_o <= 1'b1;
        ARCL_MODE_CC: const_curr_flag_o <= 1'b1;
        ARCL_MODE_CP: const_pow_flag_o <= 1'b1;
        default: const_volt_flag_o <= 1'b0;
      endcase
    end
  end

  // ----------------------------------------
  // Setpoints
  // ----------------------------------------
  arcl_scaler u_vscale (
    .sample_i(external_setpoint_voltage_i),
    .range_10v_i(range_10v_i),
    .scaled_o(v_scaled)
  );
  arcl_scaler u_iscale (
    .sample_i(external_setpoint_current_i),
    .range_10v_i(range_10v_i),
    .scaled_o(i_scaled)
  );

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      volt_set_o <= `ARCL_ZERO_OUT;
      curr_set_o <= `ARCL_ZERO_OUT;
    end else begin
      volt_set_o <= (ext_en & volt_ctrl_sel_i) ? v_scaled : panel_volt_set_i;
      curr_set_o <= (ext_en & curr_ctrl_sel_i) ? i_scaled : panel_curr_set_i;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_CLEAR: assert property (@(posedge clock_i) disable iff (rst_i)
    (ext_en && alarm_clear_in_i && !alarm_shutdown_i && !protection_trip_i) |=> !fault_flag_o)
    else $error("alarm not cleared");
  AST_SHUT: assert property (@(posedge clock_i) disable iff (rst_i)
    (ext_en && alarm_shutdown_i) |=> !output_on_o)
    else $error("output on during shutdown");
  // Sampled reset in the antecedent: the release edge itself still resets the flops
  AST_POL_HIGH: assert property (@(posedge clock_i) disable iff (rst_i)
    (!rst_i && ext_en && !polarity_low_i && output_switch_in_i && !nxt_alarm) |=> output_on_o)
    else $error("active-high switch ignored");
  AST_OFF_HIGH: assert property (@(posedge clock_i) disable iff (rst_i)
    (ext_en && !polarity_low_i && !output_switch_in_i) |=> !output_on_o)
    else $error("active-high switch low left output on");
  AST_POL_LOW: assert property (@(posedge clock_i) disable iff (rst_i)
    (!rst_i && ext_en && polarity_low_i && !output_switch_in_i && !nxt_alarm) |=> output_on_o)
    else $error("active-low switch ignored");
  AST_OFF_LOW: assert property (@(posedge clock_i) disable iff (rst_i)
    (ext_en && polarity_low_i && output_switch_in_i) |=> !output_on_o)
    else $error("active-low switch high left output on");
  AST_ENABLE: assert property (@(posedge clock_i) disable iff (rst_i)
    !external_control_enable_i |=> !output_on_o)
    else $error("output on without enable");
  AST_IGNORE: assert property (@(posedge clock_i) disable iff (rst_i)
    (!external_control_enable_i && fault_flag_o && !protection_trip_i) |=> fault_flag_o)
    else $error("clear acted without enable");
  AST_NOEXT_V: assert property (@(posedge clock_i) disable iff (rst_i)
    (!rst_i && !external_control_enable_i) |=> volt_set_o == $past(panel_volt_set_i))
    else $error("external voltage setpoint used without enable");
  AST_NOEXT_C: assert property (@(posedge clock_i) disable iff (rst_i)
    (!rst_i && !external_control_enable_i) |=> curr_set_o == $past(panel_curr_set_i))
    else $error("external current setpoint used without enable");
  AST_ACTIVE: assert property (@(posedge clock_i) disable iff (rst_i)
    output_active_flag_o == output_on_o)
    else $error("active flag mismatch");
  AST_PWR: assert property (@(posedge clock_i) disable iff (rst_i)
    !$past(rst_i) |-> !power_up_flag_n_o)
    else $error("power flag not low");
  AST_FAULT: assert property (@(posedge clock_i) disable iff (rst_i)
    (!rst_i && protection_trip_i) |=> fault_flag_o && !output_on_o)
    else $error("trip not flagged");
  AST_SHUT_FLAG: assert property (@(posedge clock_i) disable iff (rst_i)
    (!rst_i && ext_en && alarm_shutdown_i) |=> fault_flag_o)
    else $error("shutdown not flagged");
  AST_MODE: assert property (@(posedge clock_i) disable iff (rst_i)
    (!rst_i && reg_mode_i == 2'h1)
    |=> (const_curr_flag_o && !const_volt_flag_o && !const_pow_flag_o))
    else $error("mode flag wrong");
  AST_ONEHOT: assert property (@(posedge clock_i) disable iff (rst_i)
    (!rst_i && reg_mode_i != 2'h3)
    |=> $onehot({const_volt_flag_o, const_curr_flag_o, const_pow_flag_o}))
    else $error("mode flags not one-hot");
  AST_MODE_NONE: assert property (@(posedge clock_i) disable iff (rst_i)
    (reg_mode_i == 2'h3) |=> !(const_volt_flag_o || const_curr_flag_o || const_pow_flag_o))
    else $error("flag raised for illegal mode");
  AST_LATCH: assert property (@(posedge clock_i) disable iff (rst_i)
    (fault_flag_o && !(ext_en && alarm_clear_in_i)) |=> (fault_flag_o && !output_on_o))
    else $error("alarm dropped uncleared");
  AST_SAT: assert property (@(posedge clock_i) disable iff (rst_i)
    (!rst_i && ext_en && volt_ctrl_sel_i && external_setpoint_voltage_i == `ARCL_FULL_10V)
    |=> volt_set_o == `ARCL_OUT_FS)
    else $error("no saturation");
  AST_SAT5: assert property (@(posedge clock_i) disable iff (rst_i)
    (!rst_i && ext_en && volt_ctrl_sel_i && !range_10v_i &&
     external_setpoint_voltage_i >= `ARCL_FULL_5V) |=> volt_set_o == `ARCL_OUT_FS)
    else $error("5 V range maximum not full scale");
  AST_IFULL: assert property (@(posedge clock_i) disable iff (rst_i)
    (!rst_i && ext_en && curr_ctrl_sel_i && external_setpoint_current_i == `ARCL_FULL_10V)
    |=> curr_set_o == `ARCL_OUT_FS)
    else $error("current setpoint not full scale");
  AST_SRC: assert property (@(posedge clock_i) disable iff (rst_i)
    (!rst_i && !curr_ctrl_sel_i) |=> curr_set_o == $past(panel_curr_set_i))
    else $error("current source wrong");
endmodule : arcl_top

// *** arcl_remote_model.sv ***
// Model of the external controller driving the rear connector pins
`timescale 1ns/1ns
module arcl_remote_model (
  input wire logic ctrl_active_i,
  input wire logic want_on_i,
  input wire logic pol_low_i,
  output logic external_control_enable_o,
  output logic output_switch_in_o,
  output logic polarity_low_o
);
  // Enable held high all the time control is wanted
  assign external_control_enable_o = ctrl_active_i;
  // Pin level inverted for active-low, so callers think in on/off
  assign output_switch_in_o = want_on_i ^ pol_low_i;
  assign polarity_low_o = pol_low_i;
endmodule : arcl_remote_model

// *** test_arcl_top.sv ***
// Testbench for the analog remote control logic
`timescale 1ns/1ns
`include "arcl_params.svh"
module test_arcl_top;
  logic clk, rst, clr, shut, want, act, pol, trip, r10, vsel, csel;
  logic [1:0] mode;
  logic [11:0] sv, sc;
  logic [15:0] pv, pc, vo, co;
  logic en, sw, pl, on, actf, pwr_n, flt, cv, cc, cp;
  int fail_count = 0;
  int checked = 0;
  logic [11:0] tab [5] = '{12'h000, 12'h400, 12'h800, 12'h900, 12'hFFF};
  arcl_remote_model ctl (.ctrl_active_i(act), .want_on_i(want), .pol_low_i(pol),
    .external_control_enable_o(en), .output_switch_in_o(sw), .polarity_low_o(pl));
  arcl_top uut (.clock_i(clk), .rst_i(rst), .alarm_clear_in_i(clr), .alarm_shutdown_i(shut),
    .output_switch_in_i(sw), .external_control_enable_i(en), .polarity_low_i(pl),
    .protection_trip_i(trip), .range_10v_i(r10), .volt_ctrl_sel_i(vsel),
    .curr_ctrl_sel_i(csel), .reg_mode_i(mode), .external_setpoint_voltage_i(sv),
    .external_setpoint_current_i(sc), .panel_volt_set_i(pv), .panel_curr_set_i(pc),
    .output_on_o(on), .output_active_flag_o(actf), .power_up_flag_n_o(pwr_n),
    .fault_flag_o(flt), .const_volt_flag_o(cv), .const_curr_flag_o(cc),
    .const_pow_flag_o(cp), .volt_set_o(vo), .curr_set_o(co));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Expected scaling, saturating at the range maximum
  function automatic logic [15:0] scl(input logic [11:0] s, input logic r);
    logic [31:0] m;
    m = r ? 32'(`ARCL_FULL_10V) : 32'(`ARCL_FULL_5V);
    scl = (32'(s) >= m) ? `ARCL_OUT_FS : 16'((32'(s) * 32'h0000FFFF) / m);
  endfunction : scl
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Two edges: the first samples the pins and registers the answer, the second is margin
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask : settle
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test
  initial begin
    #20000;
    fail_count++;
    end_of_test();
  end
  initial begin
    {rst, clr, shut, want, act, pol, trip, r10, vsel, csel} <= 10'h203;
    {mode, sv, sc, pv, pc} <= '0;
    repeat (5) @(posedge clk);
    #1;
    chk(16'({on, actf, flt, pwr_n, cv, cc, cp}), 16'h0008);
    chk(vo | co, 16'h0000);
    @(posedge clk) rst <= 1'b0;
    settle();
    chk(16'(pwr_n), 16'h0000);
    for (int p = 0; p < 2; p++) for (int w = 0; w < 2; w++) begin
      @(posedge clk) {act, pol, want} <= {1'b1, 1'(p), 1'(w)};
      settle();
      chk(16'({on, actf}), w ? 16'h0003 : 16'h0000);
    end
    @(posedge clk) {act, pol, shut} <= 3'h1;
    settle();
    chk(16'({on, flt}), 16'h0000);
    $display("switch and enable test done");
    @(posedge clk) act <= 1'b1;
    settle();
    chk(16'({on, flt}), 16'h0001);
    @(posedge clk) shut <= 1'b0;
    settle();
    chk(16'({on, flt}), 16'h0001);
    @(posedge clk) clr <= 1'b1;
    settle();
    chk(16'({on, flt}), 16'h0002);
    @(posedge clk) {clr, act, trip} <= 3'h1;
    settle();
    chk(16'(flt), 16'h0001);
    // Clear without enable must leave the alarm latched
    @(posedge clk) {clr, trip} <= 2'h2;
    settle();
    chk(16'(flt), 16'h0001);
    @(posedge clk) act <= 1'b1;
    settle();
    chk(16'(flt), 16'h0000);
    // Clear held high still loses to a live trip
    @(posedge clk) trip <= 1'b1;
    settle();
    chk(16'({on, flt}), 16'h0001);
    $display("alarm test done");
    @(posedge clk) rst <= 1'b1;
    settle();
    chk(16'({on, actf, flt, pwr_n, cv, cc, cp}), 16'h0008);
    chk(vo | co, 16'h0000);
    @(posedge clk) rst <= 1'b0;
    settle();
    chk(16'({pwr_n, on, flt}), 16'h0001);
    @(posedge clk) trip <= 1'b0;
    settle();
    chk(16'({on, actf, flt}), 16'h0006);
    $display("reset test done");
    for (int m = 0; m < 4; m++) begin
      @(posedge clk) mode <= 2'(m);
      settle();
      chk(16'({cv, cc, cp}), 16'(m == 3 ? 0 : 4 >> m));
    end
    $display("mode test done");
    for (int r = 0; r < 2; r++) for (int i = 0; i < 5; i++) begin
      @(posedge clk) {r10, sv, sc} <= {1'(r), tab[i], tab[4 - i]};
      settle();
      chk(vo, scl(tab[i], 1'(r)));
      chk(co, scl(tab[4 - i], 1'(r)));
    end
    // Selections stay on, but enable low must fall back to the panel values
    @(posedge clk) {act, pv, pc} <= {1'b0, 16'h1234, 16'hABCD};
    settle();
    chk(vo, 16'h1234);
    chk(co, 16'hABCD);
    @(posedge clk) {act, vsel, csel} <= 3'h4;
    settle();
    chk(vo, 16'h1234);
    chk(co, 16'hABCD);
    $display("setpoint test done");
    end_of_test();
  end
endmodule : test_arcl_top
